// file: hdl/low_power_mode_controller.sv
// low-power mode controller: wait, active halt, halt and auto-wake halt with their exits
// assumes cpu strobes are one-cycle pulses on clock_in; awu_rc_clk_in is asynchronous
`timescale 1ns/1ps
`include "lpm_regs.svh"
module low_power_mode_controller (
    input  wire logic                clock_in,
    input  wire logic                rst_n_in,
    // cpu instruction side
    input  wire logic                opcode_valid_in,
    input  wire logic [7:0]          opcode_in,
    input  wire logic                wait_instruction_in,
    input  wire logic                ccr_pop_in,
    input  wire logic                ccr_pop_mask_in,
    // mode selection from the timers
    input  wire logic                timebase_irq_enable_in,
    input  wire logic                overflow_irq_enable_in,
    input  wire logic                autoreload_clk_sel_hi_in,
    input  wire logic                autoreload_clk_sel_lo_in,
    // watchdog
    input  wire logic                watchdog_enabled_in,
    input  wire logic                watchdog_on_halt_option_in,
    // wake sources
    input  wire logic                irq_pending_in,
    input  wire logic                halt_wake_irq_in,
    input  wire logic                timer_wake_irq_in,
    input  wire logic                reset_req_in,
    // auto-wake control and prescaler access
    input  wire logic                ctrl_write_in,
    input  wire logic [7:0]          ctrl_wdata_in,
    input  wire logic                ctrl_read_in,
    input  wire logic                presc_write_in,
    input  wire lpm_pkg::presc_t     presc_wdata_in,
    input  wire logic                awu_rc_clk_in,
    // outputs
    output lpm_pkg::lpm_state_e      mode_out,
    output logic                     cpu_stop_out,
    output logic                     interrupt_mask_out,
    output logic                     main_osc_enable_out,
    output logic                     periph_clk_enable_out,
    output logic                     timer_clk_enable_out,
    output logic                     awu_rc_enable_out,
    output logic                     capture_route_awu_out,
    output logic                     service_irq_out,
    output logic                     fetch_reset_vector_out,
    output logic                     watchdog_reset_out,
    output logic [7:0]               auto_wake_ctrl_status_out,
    output lpm_pkg::presc_t          auto_wake_prescaler_out,
    output logic                     auto_wake_irq_out
);
    import lpm_pkg::*;

    awu_if awu ();

    lpm_state_e state_r;
    lpm_state_e state_nxt;
    logic [6:0] startup_cnt_r;
    logic [6:0] startup_cnt_nxt;
    logic       cause_reset_r;       // wake cause held through the start-up delay
    logic       cause_reset_nxt;
    logic       mask_r;
    logic       mask_nxt;
    logic       service_r;
    logic       service_nxt;
    logic       fetch_r;
    logic       fetch_nxt;
    logic       wdg_rst_r;
    logic       wdg_rst_nxt;
    logic       flag_r;
    logic       flag_nxt;
    logic       measure_r;
    logic       measure_nxt;
    logic       awu_en_r;
    logic       awu_en_nxt;
    presc_t     presc_r;
    presc_t     presc_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] rc_sync_r;
    logic       rc_level_r;
    logic       rc_level_nxt;
    logic       rc_tick;
    logic       halt_decode;
    logic       active_sel;
    logic       enter_low;

    // assemble the visible control/status byte
    function automatic logic [7:0] ctrl_byte(input logic flag, input logic meas, input logic en);
        logic [7:0] b;
        b                = 8'h00;
        b[`LPM_FLAG_BIT] = flag;
        b[`LPM_MEAS_BIT] = meas;
        b[`LPM_EN_BIT]   = en;
        return b;
    endfunction

    // rc pin: three stages, a level change counts only when stages two and three agree
    always_comb begin
        rc_level_nxt = rc_level_r;
        if (rc_sync_r[1] == rc_sync_r[2]) begin
            rc_level_nxt = rc_sync_r[2];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rc_sync_r  <= 3'h0;
            rc_level_r <= 1'b0;
        end else begin
            rc_sync_r  <= {rc_sync_r[1:0], awu_rc_clk_in};
            rc_level_r <= rc_level_nxt;
        end
    end

    assign rc_tick = rc_level_nxt & ~rc_level_r;

    // timer runs only while the rc oscillator is on in auto-wake halt
    assign awu.rc_tick = rc_tick;
    assign awu.run     = (state_r == MODE_AWU_HALT);
    assign awu.presc   = presc_r;

    awu_timer u_awu_timer (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .awu      (awu)
    );

    // halt decode and mode selection
    assign halt_decode = opcode_valid_in & (opcode_in == `LPM_HALT_OPCODE);
    assign active_sel  = timebase_irq_enable_in |
                         (overflow_irq_enable_in & ~autoreload_clk_sel_hi_in & autoreload_clk_sel_lo_in);

    // mode sequencer
    always_comb begin
        state_nxt       = state_r;
        startup_cnt_nxt = startup_cnt_r;
        cause_reset_nxt = cause_reset_r;
        service_nxt     = 1'b0;
        fetch_nxt       = 1'b0;
        wdg_rst_nxt     = 1'b0;
        enter_low       = 1'b0;
        case (state_r)
            MODE_RUN: begin
                if (reset_req_in) begin
                    fetch_nxt = 1'b1;
                end else if (wait_instruction_in) begin
                    state_nxt = MODE_WAIT;
                    enter_low = 1'b1;
                end else if (halt_decode) begin
                    if (active_sel) begin
                        state_nxt = MODE_ACTIVE_HALT;
                        enter_low = 1'b1;
                    end else if (watchdog_enabled_in && !watchdog_on_halt_option_in) begin
                        wdg_rst_nxt = 1'b1;
                    end else if (awu_en_r) begin
                        state_nxt = MODE_AWU_HALT;
                        enter_low = 1'b1;
                    end else begin
                        state_nxt = MODE_HALT;
                        enter_low = 1'b1;
                    end
                end
            end
            MODE_WAIT: begin
                if (reset_req_in) begin
                    state_nxt = MODE_RUN;
                    fetch_nxt = 1'b1;
                end else if (irq_pending_in) begin
                    state_nxt   = MODE_RUN;
                    service_nxt = 1'b1;
                end
            end
            MODE_ACTIVE_HALT: begin
                if (reset_req_in) begin
                    state_nxt       = MODE_STARTUP;
                    cause_reset_nxt = 1'b1;
                    startup_cnt_nxt = 7'd0;
                end else if (timer_wake_irq_in) begin
                    state_nxt   = MODE_RUN;
                    service_nxt = 1'b1;
                end
            end
            MODE_HALT, MODE_AWU_HALT: begin
                startup_cnt_nxt = 7'd0;
                if (reset_req_in) begin
                    state_nxt       = MODE_STARTUP;
                    cause_reset_nxt = 1'b1;
                end else if (halt_wake_irq_in || awu.expire) begin
                    state_nxt       = MODE_STARTUP;
                    cause_reset_nxt = 1'b0;
                end
            end
            MODE_STARTUP: begin
                // a reset during the delay overrides a pending interrupt wake
                if (reset_req_in) begin
                    cause_reset_nxt = 1'b1;
                end
                startup_cnt_nxt = startup_cnt_r + 7'd1;
                if (startup_cnt_r == `LPM_STARTUP_CYCLES - 7'd1) begin
                    state_nxt   = MODE_RUN;
                    fetch_nxt   = cause_reset_r | reset_req_in;
                    service_nxt = ~(cause_reset_r | reset_req_in);
                end
            end
            default: begin
                state_nxt = MODE_RUN;
            end
        endcase
    end

    // interrupt mask: cleared on entry, set for the wake routine, restored on pop
    always_comb begin
        mask_nxt = mask_r;
        if (ccr_pop_in) begin
            mask_nxt = ccr_pop_mask_in;
        end
        if (enter_low) begin
            mask_nxt = 1'b0;
        end
        if (service_r) begin
            mask_nxt = 1'b1;
        end
    end

    // auto-wake control, flag and prescaler
    always_comb begin
        flag_nxt    = flag_r;
        measure_nxt = measure_r;
        awu_en_nxt  = awu_en_r;
        presc_nxt   = presc_r;
        rdata_nxt   = rdata_r;
        if (ctrl_read_in) begin
            rdata_nxt = ctrl_byte(flag_r, measure_r, awu_en_r);
            flag_nxt  = 1'b0;
        end
        if (awu.expire) begin
            flag_nxt = 1'b1;
        end
        if (ctrl_write_in) begin
            measure_nxt = ctrl_wdata_in[`LPM_MEAS_BIT];
            awu_en_nxt  = ctrl_wdata_in[`LPM_EN_BIT];
        end
        // the forbidden zero factor is refused, old value stays
        if (presc_write_in && presc_wdata_in != `LPM_PRESC_FORBIDDEN) begin
            presc_nxt = presc_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r       <= MODE_RUN;
            startup_cnt_r <= 7'd0;
            cause_reset_r <= 1'b0;
            mask_r        <= `LPM_MASK_RESET;
            service_r     <= 1'b0;
            fetch_r       <= 1'b0;
            wdg_rst_r     <= 1'b0;
            flag_r        <= 1'b0;
            measure_r     <= 1'b0;
            awu_en_r      <= 1'b0;
            presc_r       <= `LPM_PRESC_RESET;
            rdata_r       <= 8'h00;
        end else begin
            state_r       <= state_nxt;
            startup_cnt_r <= startup_cnt_nxt;
            cause_reset_r <= cause_reset_nxt;
            mask_r        <= mask_nxt;
            service_r     <= service_nxt;
            fetch_r       <= fetch_nxt;
            wdg_rst_r     <= wdg_rst_nxt;
            flag_r        <= flag_nxt;
            measure_r     <= measure_nxt;
            awu_en_r      <= awu_en_nxt;
            presc_r       <= presc_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    // clock gating per mode; software must already sit on a slow rc clock before halt
    assign main_osc_enable_out   = (state_r == MODE_RUN) || (state_r == MODE_WAIT) ||
                                   (state_r == MODE_ACTIVE_HALT) || (state_r == MODE_STARTUP);
    assign periph_clk_enable_out = (state_r == MODE_RUN) || (state_r == MODE_WAIT);
    assign timer_clk_enable_out  = periph_clk_enable_out || (state_r == MODE_ACTIVE_HALT);
    assign capture_route_awu_out = measure_r && (state_r == MODE_RUN);
    assign awu_rc_enable_out     = capture_route_awu_out || (state_r == MODE_AWU_HALT);

    assign mode_out                  = state_r;
    assign cpu_stop_out              = (state_r != MODE_RUN);
    assign interrupt_mask_out        = mask_r;
    assign service_irq_out           = service_r;
    assign fetch_reset_vector_out    = fetch_r;
    assign watchdog_reset_out        = wdg_rst_r;
    assign auto_wake_ctrl_status_out = rdata_r;
    assign auto_wake_prescaler_out   = presc_r;
    assign auto_wake_irq_out         = flag_r;
endmodule

// file: hdl/lpm_regs.svh
// constants of the low-power mode controller: opcodes, counts, field positions, reset values
// assumes it is included by bare name from the design files that need it
// How it works
// - wait stops the cpu only; peripherals run, state other than mask kept
// - entering wait clears the interrupt mask
// - wait ends on interrupt or reset, then service routine or reset vector
// - wake service sets mask for the routine; popping the saved code restores it
// - active halt chosen by timebase enable, or overflow enable with clock select 01
// - active halt ends only on lite or auto-reload timer interrupt, or reset
// - reset ending active halt waits 64 cycles before reset vector fetch
// - interrupt ending active halt services it at once, no delay
// - entering active halt clears the mask; pending interrupt wakes immediately
// - active halt runs main oscillator and selected timer only
// - active halt with option cleared gives no watchdog reset on halt
// - halt without active halt selected enters plain halt
// - halt exit restarts oscillator, waits 64 cycles, then services or fetches vector
// - entering halt forces mask to zero; pending interrupt wakes immediately
// - halt stops main oscillator and all peripherals
// - halt with watchdog on may give a watchdog reset, per option bit
// - opcode 8e decodes as the halt instruction
// - halt with auto-wake enable set enters auto-wake halt on the rc clock
// - rc clock goes through fixed divider then programmable prescaler to end delay
// - delay end sets flag, raises interrupt, restarts oscillator, waits 64, services
// - reading the auto-wake control register clears flag and its interrupt
// - measure bit in run enables rc and routes it to timer capture
// - auto-wake halt also exits on halt-capable interrupt or reset
// - fixed divider is 64; prescaler 1..255 divides by value; zero forbidden
// - flag bit 2, measure bit 1, enable bit 0; flag not writable
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

`define LPM_HALT_OPCODE      8'h8e
`define LPM_STARTUP_CYCLES   7'd64
`define LPM_AWU_FIXED_DIV    7'd64
`define LPM_PRESC_RESET      8'hff
`define LPM_PRESC_FORBIDDEN  8'h00
`define LPM_CTRL_RESET       3'h0
`define LPM_MASK_RESET       1'b1
`define LPM_FLAG_BIT         2
`define LPM_MEAS_BIT         1
`define LPM_EN_BIT           0

`endif

// file: hdl/lpm_pkg.sv
// types shared by the low-power mode controller files
// assumes nothing beyond a SystemVerilog compiler
package lpm_pkg;

    // one-hot operating modes
    typedef enum logic [5:0] {
        MODE_RUN         = 6'b000001,
        MODE_WAIT        = 6'b000010,
        MODE_ACTIVE_HALT = 6'b000100,
        MODE_HALT        = 6'b001000,
        MODE_AWU_HALT    = 6'b010000,
        MODE_STARTUP     = 6'b100000
    } lpm_state_e;

    typedef logic [7:0] presc_t;

endpackage

// file: hdl/awu_if.sv
// carrier between the mode controller and its auto-wake timer
// assumes both ends share clock_in
`timescale 1ns/1ps
interface awu_if;
    logic                 rc_tick;  // one-cycle pulse per synchronised rc rising edge
    logic                 run;      // count while high, clear while low
    lpm_pkg::presc_t      presc;    // programmed division factor
    logic                 expire;   // one-cycle pulse at end of delay

    modport ctrl  (output rc_tick, output run, output presc, input expire);
    modport timer (input rc_tick, input run, input presc, output expire);
endinterface

// file: hdl/awu_timer.sv
// auto-wake delay timer: fixed divide-by-64, then 8-bit programmable prescaler
// assumes rc_tick is already synchronised to clock_in
`timescale 1ns/1ps
`include "lpm_regs.svh"
module awu_timer (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    awu_if.timer      awu
);
    import lpm_pkg::*;

    logic [5:0] div_r;
    logic [5:0] div_nxt;
    logic [7:0] presc_cnt_r;
    logic [7:0] presc_cnt_nxt;
    logic       expire_r;
    logic       expire_nxt;

    // divider wraps every 64 rc edges, prescaler counts wraps up to its factor
    always_comb begin
        div_nxt       = div_r;
        presc_cnt_nxt = presc_cnt_r;
        expire_nxt    = 1'b0;
        if (!awu.run) begin
            div_nxt       = 6'h00;
            presc_cnt_nxt = 8'h00;
        end else if (awu.rc_tick) begin
            div_nxt = div_r + 6'h01;
            if ({1'b0, div_r} == `LPM_AWU_FIXED_DIV - 7'd1) begin
                if (presc_cnt_r + 8'h01 >= awu.presc) begin
                    presc_cnt_nxt = 8'h00;
                    expire_nxt    = 1'b1;
                end else begin
                    presc_cnt_nxt = presc_cnt_r + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r       <= 6'h00;
            presc_cnt_r <= 8'h00;
            expire_r    <= 1'b0;
        end else begin
            div_r       <= div_nxt;
            presc_cnt_r <= presc_cnt_nxt;
            expire_r    <= expire_nxt;
        end
    end

    assign awu.expire = expire_r;
endmodule

// file: testbench/lpm_checker.sv
// ports-only checks of mode changes, clock gating and wake timing of the controller
// assumes the controller top ports by name; attached by the bind at the foot
`timescale 1ns/1ps
module lpm_checker
    import lpm_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    input wire logic       irq_pending_in,
    input wire logic       halt_wake_irq_in,
    input wire logic       timer_wake_irq_in,
    input wire logic       reset_req_in,
    input wire lpm_state_e mode_out,
    input wire logic       interrupt_mask_out,
    input wire logic       main_osc_enable_out,
    input wire logic       periph_clk_enable_out,
    input wire logic       timer_clk_enable_out,
    input wire logic       service_irq_out,
    input wire logic       fetch_reset_vector_out,
    input wire logic       auto_wake_irq_out
);
    logic [6:0] stay_r;
    logic [6:0] stay_nxt;
    logic       low_w;
    logic       halt_w;

    // mode groups used by several properties
    assign low_w  = mode_out inside {MODE_WAIT, MODE_ACTIVE_HALT, MODE_HALT, MODE_AWU_HALT};
    assign halt_w = mode_out inside {MODE_HALT, MODE_AWU_HALT};

    // startup length counter; cleared outside startup so a short stay shows up
    always_comb begin
        stay_nxt = (mode_out == MODE_STARTUP) ? stay_r + 7'd1 : 7'd0;
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stay_r <= 7'd0;
        end else begin
            stay_r <= stay_nxt;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    AST_LOW_MASK: assert property (low_w |-> !interrupt_mask_out)
        else $error("mask set in a low-power mode");
    AST_WAIT_EXIT: assert property (mode_out == MODE_WAIT && irq_pending_in && !reset_req_in
        |=> mode_out == MODE_RUN && service_irq_out) else $error("wait did not end on interrupt");
    AST_AH_EXIT: assert property (mode_out == MODE_ACTIVE_HALT && timer_wake_irq_in && !reset_req_in
        |=> mode_out == MODE_RUN && service_irq_out) else $error("active halt slow to service");
    AST_AH_HOLD: assert property (mode_out == MODE_ACTIVE_HALT && !timer_wake_irq_in && !reset_req_in
        |=> mode_out == MODE_ACTIVE_HALT) else $error("active halt left without cause");
    AST_HALT_START: assert property ((halt_w && (halt_wake_irq_in || reset_req_in))
        || (mode_out == MODE_ACTIVE_HALT && reset_req_in) |=> mode_out == MODE_STARTUP)
        else $error("no startup after wake");
    AST_STARTUP_LEN: assert property (mode_out != MODE_STARTUP && stay_r != 7'd0
        |-> stay_r == 7'd64 && (service_irq_out || fetch_reset_vector_out)) else $error("startup length wrong");
    AST_AH_CLOCKS: assert property (mode_out == MODE_ACTIVE_HALT
        |-> main_osc_enable_out && timer_clk_enable_out && !periph_clk_enable_out) else $error("active halt clocks");
    AST_HALT_CLOCKS: assert property (halt_w
        |-> !(main_osc_enable_out || periph_clk_enable_out || timer_clk_enable_out)) else $error("halt clocks");
    AST_RESET_WINS: assert property (mode_out == MODE_WAIT && reset_req_in
        |=> fetch_reset_vector_out && !service_irq_out) else $error("reset lost to interrupt");
    AST_SVC_MASK: assert property ($rose(service_irq_out) |=> interrupt_mask_out)
        else $error("mask not set for service");
    AST_AWU_FLAG: assert property ($past(mode_out) == MODE_AWU_HALT && mode_out == MODE_STARTUP
        && !$past(halt_wake_irq_in) && !$past(reset_req_in) |-> auto_wake_irq_out) else $error("flag not set");
endmodule

bind low_power_mode_controller lpm_checker chk_i (.*);

// file: testbench/awu_osc_model.sv
// behavioural auto-wake rc oscillator feeding the controller's rc pin
// assumes enable_in is the controller's rc enable; pin rests low while disabled
`timescale 1ns/1ps
module awu_osc_model #(
    parameter int HALF_NS = 20
) (
    input  wire logic enable_in,
    output logic      rc_out
);
    initial rc_out = 1'b0;

    // toggles only while enabled; 4 clocks per half period meets the sync minimum
    always begin
        wait (enable_in === 1'b1);
        #(HALF_NS) rc_out = ~rc_out;
        if (enable_in !== 1'b1) rc_out = 1'b0;
    end
endmodule

// file: testbench/testbench.sv
// self-checking bench of the low-power mode controller
// assumes the controller, its package and the rc oscillator model
`timescale 1ns/1ps
module testbench;
    import lpm_pkg::*;
    logic clock_in = 1'b0, rst_n_in = 1'b0, opcode_valid_in = 1'b0, wait_instruction_in = 1'b0;
    logic ccr_pop_in = 1'b0, ccr_pop_mask_in = 1'b0, timebase_irq_enable_in = 1'b0;
    logic overflow_irq_enable_in = 1'b0, autoreload_clk_sel_hi_in = 1'b0, autoreload_clk_sel_lo_in = 1'b0;
    logic watchdog_enabled_in = 1'b0, watchdog_on_halt_option_in = 1'b0, irq_pending_in = 1'b0;
    logic halt_wake_irq_in = 1'b0, timer_wake_irq_in = 1'b0, reset_req_in = 1'b0;
    logic ctrl_write_in = 1'b0, ctrl_read_in = 1'b0, presc_write_in = 1'b0, awu_rc_clk_in;
    logic [7:0] opcode_in = 8'h00, ctrl_wdata_in = 8'h00, auto_wake_ctrl_status_out;
    presc_t presc_wdata_in = 8'h00, auto_wake_prescaler_out;
    lpm_state_e mode_out;
    logic cpu_stop_out, interrupt_mask_out, main_osc_enable_out, periph_clk_enable_out;
    logic timer_clk_enable_out, awu_rc_enable_out, capture_route_awu_out, service_irq_out;
    logic fetch_reset_vector_out, watchdog_reset_out, auto_wake_irq_out;
    int bad_count = 0, total_checks = 0, cycles = 0, n;

    low_power_mode_controller DUT (.*);
    awu_osc_model rc_i (.enable_in(awu_rc_enable_out), .rc_out(awu_rc_clk_in));

    always #2.5 clock_in = ~clock_in;

    // hang guard, well above the ~820 cycles the sequence needs
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // wide enough for a cycle count packed beside a flag, so no bit is cut
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clock_in);
    endtask

    // one-cycle instruction strobe; mode is settled on return
    task automatic exec(input logic [7:0] op);
        opcode_in = op;
        opcode_valid_in = 1'b1;
        cyc(1);
        opcode_valid_in = 1'b0;
    endtask

    task automatic ctrl_wr(input logic [7:0] d);
        ctrl_wdata_in = d;
        ctrl_write_in = 1'b1;
        cyc(1);
        ctrl_write_in = 1'b0;
    endtask

    task automatic ctrl_rd();
        ctrl_read_in = 1'b1;
        cyc(1);
        ctrl_read_in = 1'b0;
    endtask

    task automatic presc_wr(input presc_t d);
        presc_wdata_in = d;
        presc_write_in = 1'b1;
        cyc(1);
        presc_write_in = 1'b0;
    endtask

    // bounded wait; n is the number of cycles it took
    task automatic wait_mode(input lpm_state_e m);
        n = 0;
        while (mode_out !== m && n < 1000) begin
            cyc(1);
            n++;
        end
    endtask

    initial begin
        cyc(16);
        rst_n_in = 1'b1;
        cyc(1);
        chk({mode_out, interrupt_mask_out}, {MODE_RUN, 1'b1});
        chk(auto_wake_prescaler_out, 8'hff);
        chk(auto_wake_ctrl_status_out, 8'h00);
        // wait: stop cpu, peripherals on, then wake by interrupt
        wait_instruction_in = 1'b1;
        cyc(1);
        wait_instruction_in = 1'b0;
        chk({mode_out, cpu_stop_out, periph_clk_enable_out}, {MODE_WAIT, 2'b11});
        chk(interrupt_mask_out, 1'b0);
        irq_pending_in = 1'b1;
        cyc(1);
        irq_pending_in = 1'b0;
        chk({mode_out, service_irq_out}, {MODE_RUN, 1'b1});
        cyc(1);
        chk(interrupt_mask_out, 1'b1);
        ccr_pop_in = 1'b1;
        cyc(1);
        chk(interrupt_mask_out, 1'b0);
        // pop held a second cycle with a saved mask of one: restore, not clear
        ccr_pop_mask_in = 1'b1;
        cyc(1);
        ccr_pop_in = 1'b0;
        chk(interrupt_mask_out, 1'b1);
        // reset and interrupt together during wait
        wait_instruction_in = 1'b1;
        cyc(1);
        wait_instruction_in = 1'b0;
        irq_pending_in = 1'b1;
        reset_req_in = 1'b1;
        cyc(1);
        irq_pending_in = 1'b0;
        reset_req_in = 1'b0;
        chk({mode_out, service_irq_out, fetch_reset_vector_out}, {MODE_RUN, 2'b01});
        // active halt by timebase; a halt-only interrupt must not wake it
        timebase_irq_enable_in = 1'b1;
        halt_wake_irq_in = 1'b1;
        exec(8'h8f);
        chk(mode_out, MODE_RUN);
        cyc(1);
        exec(8'h8e);
        chk(mode_out, MODE_ACTIVE_HALT);
        chk({main_osc_enable_out, timer_clk_enable_out, periph_clk_enable_out}, 3'b110);
        cyc(3);
        chk(mode_out, MODE_ACTIVE_HALT);
        halt_wake_irq_in = 1'b0;
        timer_wake_irq_in = 1'b1;
        cyc(1);
        chk({mode_out, service_irq_out}, {MODE_RUN, 1'b1});
        cyc(1);
        exec(8'h8e);
        chk(mode_out, MODE_ACTIVE_HALT);
        cyc(1);
        chk({mode_out, service_irq_out}, {MODE_RUN, 1'b1});
        timer_wake_irq_in = 1'b0;
        // let the service cycle pass; the cpu cannot halt while it takes the vector
        cyc(1);
        // active halt by overflow with select 01, watchdog on, then reset exit
        timebase_irq_enable_in = 1'b0;
        overflow_irq_enable_in = 1'b1;
        autoreload_clk_sel_lo_in = 1'b1;
        watchdog_enabled_in = 1'b1;
        exec(8'h8e);
        chk({mode_out, watchdog_reset_out}, {MODE_ACTIVE_HALT, 1'b0});
        reset_req_in = 1'b1;
        cyc(1);
        reset_req_in = 1'b0;
        chk(mode_out, MODE_STARTUP);
        wait_mode(MODE_RUN);
        chk({8'(n), fetch_reset_vector_out}, {8'd64, 1'b1});
        // select 11 disables active halt: watchdog reset, then plain halt
        autoreload_clk_sel_hi_in = 1'b1;
        exec(8'h8e);
        chk({mode_out, watchdog_reset_out}, {MODE_RUN, 1'b1});
        cyc(1);
        watchdog_on_halt_option_in = 1'b1;
        exec(8'h8e); // cpu clock assumed already on the slow source
        chk(mode_out, MODE_HALT);
        chk({main_osc_enable_out, periph_clk_enable_out, timer_clk_enable_out}, 3'b000);
        halt_wake_irq_in = 1'b1;
        cyc(1);
        halt_wake_irq_in = 1'b0;
        wait_mode(MODE_RUN);
        chk({8'(n), service_irq_out}, {8'd64, 1'b1});
        // auto-wake control, prescaler and measurement
        ctrl_wr(8'h07);
        chk({capture_route_awu_out, awu_rc_enable_out}, 2'b11);
        ctrl_rd();
        chk(auto_wake_ctrl_status_out, 8'h03);
        presc_wr(8'h00);
        chk(auto_wake_prescaler_out, 8'hff);
        cyc(1);
        presc_wr(8'h01);
        chk(auto_wake_prescaler_out, 8'h01);
        ctrl_wr(8'h01);
        exec(8'h8e);
        chk({mode_out, capture_route_awu_out}, {MODE_AWU_HALT, 1'b0});
        wait_mode(MODE_STARTUP);
        chk(8'(n >= 505 && n <= 525), 8'h01);
        chk(auto_wake_irq_out, 1'b1);
        wait_mode(MODE_RUN);
        chk({8'(n), service_irq_out}, {8'd64, 1'b1});
        ctrl_rd();
        chk({auto_wake_ctrl_status_out, auto_wake_irq_out}, {8'h05, 1'b0});
        exec(8'h8e);
        halt_wake_irq_in = 1'b1;
        cyc(1);
        halt_wake_irq_in = 1'b0;
        chk(mode_out, MODE_STARTUP);
        wait_mode(MODE_RUN);
        chk({8'(n), service_irq_out}, {8'd64, 1'b1});
        end_sim();
    end
endmodule
